// [src/cch_top.sv]
// Counter compare stage with hysteresis and process/diagnostic interrupt sequencing
// Summary of operation
// - Hysteresis width programmable 0 to 255
// - Width 0 or 1 disables hysteresis
// - Width change applies at next compare hit
// - Active hysteresis holds result inside window
// - New window only on next compare hit
// - At-or-above: leaving window while above keeps output
// - At-or-above: no re-assert while window active
// - Zero pulse: set on equality, clear leaving window
// - Pulse: emit pulse, open window, store direction
// - Pulse: no further pulse inside window
// - Pulse: opposite exit gives pulse, closes window
// - Pulse: same-direction exit closes window silently
// - Selectable triggers: inputs, gate, overflow, compare
// - Input edges in two event bytes
// - Counter event nibbles, two counters per byte
// - One global diagnostic interrupt enable
// - Recurring event raises pre-empting diagnostic interrupt
// - Queued diagnostics first, then queued process
// - Drop channel events until going diagnostic
// - Fault indicator on while diagnostics outstanding; log each
// - Diagnostic byte 0 fault bit layout
// - Diagnostic byte 1 class, byte 2 supply
// - Pulse length in 2.048 ms steps
`timescale 1ns/1ps
`include "cch_consts.svh"
module cch_top #(
    parameter int unsigned PULSE_STEP_CYC = `CCH_PULSE_STEP_CYC
) (
    input  wire logic                      ref_clk,
    input  wire logic                      rst,
    input  wire cch_pkg::cch_core_s [3:0]  core_in,
    input  wire logic [15:0]               in_pins,
    input  wire logic [3:0]                trig_en,
    input  wire logic                      diag_en,
    input  wire cch_pkg::cch_diag_s        diag_in,
    input  wire logic                      proc_done,
    input  wire logic                      diag_done,
    input  wire logic                      rd_en,
    input  wire logic [3:0]                rd_addr,
    output logic [3:0]                     cmp_out,
    output logic                           process_irq_handler,
    output logic                           diag_irq_handler,
    output logic                           diag_going,
    output logic [4:0]                     diag_chan,
    output logic                           diag_log,
    output logic                           system_fault_indicator,
    output logic [7:0]                     rd_data
);

    // Lowest set bit of an event vector
    function automatic logic [4:0] first_bit(input logic [31:0] v);
        logic [4:0] r;
        r = 5'd0;
        for (int i = 31; i >= 0; i--) begin
            if (v[i]) begin
                r = 5'(i);
            end
        end
        return r;
    endfunction

    // One step of a compare stage
    function automatic cch_pkg::cch_cmp_s cmp_step(input cch_pkg::cch_cmp_s s,
                                                   input cch_pkg::cch_core_s c,
                                                   input logic tick);
        cch_pkg::cch_cmp_s n;
        logic signed [32:0] d;
        logic [32:0]        mag;
        logic               hen;
        logic               eq;
        logic               raw;
        logic               leave;
        n = s;
        n.reach = 1'b0;
        eq = (c.value == c.cmp);
        hen = (c.hyst > `CCH_HYST_OFF_MAX);
        if (c.mode == cch_pkg::CCH_MODE_GE) begin
            raw = ($signed(c.value) >= $signed(c.cmp));
        end else if (c.mode == cch_pkg::CCH_MODE_LE) begin
            raw = ($signed(c.value) <= $signed(c.cmp));
        end else begin
            raw = eq;
        end
        d = $signed({c.value[31], c.value}) - $signed({s.center[31], s.center});
        mag = d[32] ? 33'(-d) : 33'(d);
        leave = s.act && (mag >= {25'h000_0000, s.width});
        n.eq = eq;
        if (s.ptim != 8'h00 && tick) begin
            n.ptim = s.ptim - 8'h01;
        end
        case (c.mode)
            cch_pkg::CCH_MODE_GE, cch_pkg::CCH_MODE_LE: begin
                if (s.act) begin
                    // hold inside, follow raw on exit
                    if (leave) begin
                        n.act = 1'b0;
                        n.out = raw;
                    end
                end else begin
                    n.out = raw;
                    // window opens only on a new hit
                    if (raw && !s.out) begin
                        n.reach = 1'b1;
                        n.act = hen;
                        n.center = c.cmp;
                        n.width = c.hyst;
                    end
                end
            end
            cch_pkg::CCH_MODE_PULSE: begin
                if (c.dur == 8'h00) begin
                    if (s.act) begin
                        if (leave) begin
                            n.act = 1'b0;
                            n.out = 1'b0;
                        end
                    end else begin
                        n.out = eq;
                        if (eq) begin
                            n.reach = !s.out;
                            n.act = hen;
                            n.center = c.cmp;
                            n.width = c.hyst;
                        end
                    end
                end else begin
                    if (s.act) begin
                        if (leave) begin
                            n.act = 1'b0;
                            if (c.up != s.dir && n.ptim == 8'h00) begin
                                n.ptim = c.dur;
                            end
                        end
                    end else if (eq && (hen || !s.eq)) begin
                        n.reach = 1'b1;
                        n.act = hen;
                        n.dir = c.up;
                        n.center = c.cmp;
                        n.width = c.hyst;
                        if (n.ptim == 8'h00) begin
                            n.ptim = c.dur;
                        end
                    end
                    n.out = (n.ptim != 8'h00);
                end
            end
            default: begin
                n.act = 1'b0;
                n.out = 1'b0;
            end
        endcase
        return n;
    endfunction

    // Compare stage and pulse prescaler
    cch_pkg::cch_cmp_s cst_q [4];
    logic [31:0]       pre_q;
    logic              tick_w;
    logic [15:0]       in_prev_q;
    logic [3:0]        gate_prev_q;

    assign tick_w = (pre_q == 32'(PULSE_STEP_CYC - 1));

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pre_q <= 32'h0000_0000;
        end else begin
            pre_q <= tick_w ? 32'h0000_0000 : pre_q + 32'h0000_0001;
        end
    end

    // width held per counter from core input
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int k = 0; k < 4; k++) begin
                cst_q[k] <= '0;
            end
        end else begin
            for (int k = 0; k < 4; k++) begin
                cst_q[k] <= cmp_step(cst_q[k], core_in[k], tick_w);
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            in_prev_q <= 16'h0000;
            gate_prev_q <= 4'h0;
        end else begin
            in_prev_q <= in_pins;
            for (int k = 0; k < 4; k++) begin
                gate_prev_q[k] <= core_in[k].gate;
            end
        end
    end

    always_comb begin
        for (int k = 0; k < 4; k++) begin
            cmp_out[k] = cst_q[k].out;
        end
    end

    // Event vector assembly
    logic [31:0] ev_w;

    always_comb begin
        ev_w = `CCH_RST_EVENTS;
        ev_w[15:0] = (in_pins ^ in_prev_q) & {16{trig_en[0]}};
        for (int k = 0; k < 4; k++) begin
            ev_w[`CCH_EV_CNT_BASE + 4 * k + `CCH_EV_GATE_OPEN] = core_in[k].gate & ~gate_prev_q[k] & trig_en[1];
            ev_w[`CCH_EV_CNT_BASE + 4 * k + `CCH_EV_GATE_CLOSE] = ~core_in[k].gate & gate_prev_q[k] & trig_en[1];
            ev_w[`CCH_EV_CNT_BASE + 4 * k + `CCH_EV_OVF] = core_in[k].ovf & trig_en[2];
            ev_w[`CCH_EV_CNT_BASE + 4 * k + `CCH_EV_CMP] = cst_q[k].reach & trig_en[3];
        end
    end

    // Interrupt sequencing state
    cch_pkg::cch_irq_st_e st_q;
    logic [31:0]          pend_q;
    logic [31:0]          svc_q;
    logic [31:0]          lost_q;
    logic [31:0]          go_q;
    logic                 ret_q;
    logic [4:0]           fifo_q [`CCH_QDEPTH];
    logic [`CCH_QPTR_W-1:0] wp_q;
    logic [`CCH_QPTR_W-1:0] rp_q;

    logic        busy_w;
    logic [31:0] lost_new_w;
    logic [31:0] accept_w;
    logic        q_empty_w;
    logic        q_full_w;
    logic        push_w;
    logic        pop_w;
    logic [4:0]  go_idx_w;
    logic        diag_ready_w;

    assign busy_w = (st_q != cch_pkg::CCH_ST_IDLE);
    assign lost_new_w = ev_w & svc_q & ~lost_q & {32{busy_w}};
    // drop events of a channel in diagnostic
    assign accept_w = ev_w & ~lost_q & ~lost_new_w;
    assign q_empty_w = (wp_q == rp_q);
    assign q_full_w = (wp_q[`CCH_QPTR_W-1] != rp_q[`CCH_QPTR_W-1])
                      && (wp_q[`CCH_QPTR_W-2:0] == rp_q[`CCH_QPTR_W-2:0]);
    assign push_w = (lost_new_w != 32'h0000_0000) && diag_en && !q_full_w;
    assign diag_ready_w = !q_empty_w && diag_en;
    assign pop_w = diag_ready_w && (st_q != cch_pkg::CCH_ST_DIAG);
    assign go_idx_w = first_bit(go_q);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wp_q <= '0;
            for (int i = 0; i < `CCH_QDEPTH; i++) begin
                fifo_q[i] <= 5'd0;
            end
        end else if (push_w) begin
            fifo_q[wp_q[`CCH_QPTR_W-2:0]] <= first_bit(lost_new_w);
            wp_q <= wp_q + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_q <= cch_pkg::CCH_ST_IDLE;
            pend_q <= `CCH_RST_EVENTS;
            svc_q <= `CCH_RST_EVENTS;
            lost_q <= `CCH_RST_EVENTS;
            go_q <= `CCH_RST_EVENTS;
            ret_q <= 1'b0;
            rp_q <= '0;
            process_irq_handler <= 1'b0;
            diag_irq_handler <= 1'b0;
            diag_going <= 1'b0;
            diag_chan <= 5'd0;
            diag_log <= 1'b0;
        end else begin
            diag_log <= 1'b0;
            pend_q <= pend_q | accept_w;
            lost_q <= lost_q | lost_new_w;
            if (pop_w) begin
                rp_q <= rp_q + 1'b1;
            end
            case (st_q)
                cch_pkg::CCH_ST_IDLE: begin
                    if (diag_ready_w) begin
                        st_q <= cch_pkg::CCH_ST_DIAG;
                        ret_q <= 1'b0;
                        diag_irq_handler <= 1'b1;
                        diag_going <= 1'b0;
                        diag_chan <= fifo_q[rp_q[`CCH_QPTR_W-2:0]];
                        diag_log <= 1'b1;
                    end else if (go_q != 32'h0000_0000 && diag_en) begin
                        st_q <= cch_pkg::CCH_ST_DIAG;
                        ret_q <= 1'b0;
                        diag_irq_handler <= 1'b1;
                        diag_going <= 1'b1;
                        diag_chan <= go_idx_w;
                        diag_log <= 1'b1;
                    end else if (pend_q != 32'h0000_0000) begin
                        st_q <= cch_pkg::CCH_ST_PROC;
                        svc_q <= pend_q;
                        pend_q <= accept_w;
                        process_irq_handler <= 1'b1;
                    end
                end
                cch_pkg::CCH_ST_PROC: begin
                    if (diag_ready_w) begin
                        st_q <= cch_pkg::CCH_ST_DIAG;
                        ret_q <= 1'b1;
                        process_irq_handler <= 1'b0;
                        diag_irq_handler <= 1'b1;
                        diag_going <= 1'b0;
                        diag_chan <= fifo_q[rp_q[`CCH_QPTR_W-2:0]];
                        diag_log <= 1'b1;
                    end else if (proc_done) begin
                        st_q <= cch_pkg::CCH_ST_IDLE;
                        svc_q <= `CCH_RST_EVENTS;
                        process_irq_handler <= 1'b0;
                        // going once the process is ready
                        if (diag_en) begin
                            go_q <= go_q | (svc_q & (lost_q | lost_new_w));
                        end else begin
                            lost_q <= (lost_q | lost_new_w) & ~svc_q;
                        end
                    end
                end
                cch_pkg::CCH_ST_DIAG: begin
                    if (diag_done) begin
                        diag_irq_handler <= 1'b0;
                        if (diag_going) begin
                            lost_q[diag_chan] <= 1'b0;
                            go_q[diag_chan] <= 1'b0;
                        end
                        if (ret_q) begin
                            st_q <= cch_pkg::CCH_ST_PROC;
                            process_irq_handler <= 1'b1;
                        end else begin
                            st_q <= cch_pkg::CCH_ST_IDLE;
                        end
                    end
                end
                default: begin
                    st_q <= cch_pkg::CCH_ST_IDLE;
                end
            endcase
        end
    end

    // fault indicator while channels are lost
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            system_fault_indicator <= 1'b0;
        end else begin
            system_fault_indicator <= ((lost_q | lost_new_w) != 32'h0000_0000);
        end
    end

    // Record read decode
    logic       chan_err_w;
    logic [7:0] d0_w;
    logic [7:0] d1_w;
    logic [7:0] d2_w;
    logic [7:0] rd_mux_w;

    assign chan_err_w = (lost_q != 32'h0000_0000);
    assign d0_w = (8'(diag_in.mod_fail) << `CCH_D0_MOD_FAIL)
                | (8'(diag_in.ext_err) << `CCH_D0_EXT_ERR)
                | (8'(chan_err_w) << `CCH_D0_CHAN_ERR)
                | (8'(diag_in.aux_miss) << `CCH_D0_AUX_MISS);
    assign d1_w = {3'b000, chan_err_w, diag_in.analog ? `CCH_CLASS_ANALOG : `CCH_CLASS_DIGITAL};
    assign d2_w = 8'(diag_in.int_supply) << `CCH_D2_INT_SUPPLY;
    assign rd_mux_w = (rd_addr == `CCH_OFS_DIAG_FAULT)  ? d0_w :
                      (rd_addr == `CCH_OFS_DIAG_CLASS)  ? d1_w :
                      (rd_addr == `CCH_OFS_DIAG_SUPPLY) ? d2_w :
                      (rd_addr == `CCH_OFS_EV_IN_LOW)   ? svc_q[7:0] :
                      (rd_addr == `CCH_OFS_EV_IN_HIGH)  ? svc_q[15:8] :
                      (rd_addr == `CCH_OFS_EV_CNT_01)   ? svc_q[23:16] :
                      (rd_addr == `CCH_OFS_EV_CNT_23)   ? svc_q[31:24] : `CCH_RST_BYTE;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rd_data <= `CCH_RST_BYTE;
        end else if (rd_en) begin
            rd_data <= rd_mux_w;
        end
    end

endmodule

// [src/cch_consts.svh]
// Constants for the counter compare and interrupt block
`ifndef CCH_CONSTS_SVH
`define CCH_CONSTS_SVH

// Register offsets
`define CCH_OFS_DIAG_FAULT    4'h0
`define CCH_OFS_DIAG_CLASS    4'h1
`define CCH_OFS_DIAG_SUPPLY   4'h2
`define CCH_OFS_EV_IN_LOW     4'h8
`define CCH_OFS_EV_IN_HIGH    4'h9
`define CCH_OFS_EV_CNT_01     4'ha
`define CCH_OFS_EV_CNT_23     4'hb

// Diagnostic byte 0 fields
`define CCH_D0_MOD_FAIL       0
`define CCH_D0_EXT_ERR        2
`define CCH_D0_CHAN_ERR       3
`define CCH_D0_AUX_MISS       4
// Diagnostic byte 1 and 2 fields
`define CCH_D1_CHAN_INFO      4
`define CCH_D2_INT_SUPPLY     4
`define CCH_CLASS_ANALOG      4'h5
`define CCH_CLASS_DIGITAL     4'hf

// Counter event nibble fields
`define CCH_EV_GATE_OPEN      0
`define CCH_EV_GATE_CLOSE     1
`define CCH_EV_OVF            2
`define CCH_EV_CMP            3
`define CCH_EV_CNT_BASE       16

// Hysteresis widths of this value or below disable the window
`define CCH_HYST_OFF_MAX      8'h01

// Pulse timing
`define CCH_CLK_NS            50
`define CCH_PULSE_STEP_NS     2048000
`define CCH_PULSE_STEP_CYC    (`CCH_PULSE_STEP_NS / `CCH_CLK_NS)
`define CCH_PULSE_MAX_MS      522.24

// Lost-event queue
`define CCH_QDEPTH            8
`define CCH_QPTR_W            4

// Reset values
`define CCH_RST_BYTE          8'h00
`define CCH_RST_EVENTS        32'h0000_0000

`endif

// [src/cch_pkg.sv]
// Types for the counter compare and interrupt block
package cch_pkg;

    typedef enum logic [1:0] {
        CCH_MODE_NEVER,
        CCH_MODE_GE,
        CCH_MODE_LE,
        CCH_MODE_PULSE
    } cch_mode_e;

    typedef enum logic [1:0] {
        CCH_ST_IDLE,
        CCH_ST_PROC,
        CCH_ST_DIAG
    } cch_irq_st_e;

    // Inputs from one counter core
    typedef struct packed {
        logic [31:0] value;
        logic        up;
        logic [31:0] cmp;
        logic [7:0]  hyst;
        cch_mode_e   mode;
        logic [7:0]  dur;
        logic        gate;
        logic        ovf;
    } cch_core_s;

    // Compare stage state of one counter
    typedef struct packed {
        logic        act;
        logic        out;
        logic        dir;
        logic        eq;
        logic        reach;
        logic [31:0] center;
        logic [7:0]  width;
        logic [7:0]  ptim;
    } cch_cmp_s;

    // Static diagnostic inputs
    typedef struct packed {
        logic mod_fail;
        logic ext_err;
        logic aux_miss;
        logic int_supply;
        logic analog;
    } cch_diag_s;

endpackage

// [sim/cch_properties.sv]
// Port-level assertions for the compare and interrupt block
`timescale 1ns/1ps
module cch_properties (
    input wire logic                     ref_clk,
    input wire logic                     rst,
    input wire cch_pkg::cch_core_s [3:0] core_in,
    input wire logic [15:0]              in_pins,
    input wire logic [3:0]               trig_en,
    input wire logic                     diag_en,
    input wire cch_pkg::cch_diag_s       diag_in,
    input wire logic                     proc_done,
    input wire logic                     diag_done,
    input wire logic                     rd_en,
    input wire logic [3:0]               rd_addr,
    input wire logic [3:0]               cmp_out,
    input wire logic                     process_irq_handler,
    input wire logic                     diag_irq_handler,
    input wire logic                     diag_going,
    input wire logic [4:0]               diag_chan,
    input wire logic                     diag_log,
    input wire logic                     system_fault_indicator,
    input wire logic [7:0]               rd_data
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    fixed_zero_a: assert property (rd_en && rd_addr == 4'h0 |=> rd_data[1] == 1'b0 && rd_data[7:5] == 3'h0)
        else $error("fault byte fixed bits not zero");
    module_class_a: assert property (rd_en && rd_addr == 4'h1 |=>
        rd_data[3:0] == ($past(diag_in.analog) ? 4'h5 : 4'hf) && rd_data[7:5] == 3'h0)
        else $error("class byte wrong");
    supply_byte_a: assert property (rd_en && rd_addr == 4'h2 |=>
        rd_data == {3'h0, $past(diag_in.int_supply), 4'h0})
        else $error("supply byte wrong");
    unmapped_zero_a: assert property (rd_en && rd_addr inside {[4'h3:4'h7], [4'hc:4'hf]} |=> rd_data == 8'h00)
        else $error("unmapped read not zero");
    diag_preempt_a: assert property (diag_irq_handler |-> !process_irq_handler)
        else $error("process request during diagnostic");
    log_on_raise_a: assert property ($rose(diag_irq_handler) |-> diag_log)
        else $error("diagnostic raised without log entry");
    log_single_a: assert property (diag_log |-> diag_irq_handler ##1 !diag_log)
        else $error("log entry not a single pulse");
    fault_incoming_a: assert property (diag_irq_handler && !diag_going |-> system_fault_indicator)
        else $error("fault indicator off during incoming");
    process_hold_a: assert property (process_irq_handler && !proc_done |=>
        process_irq_handler || diag_irq_handler)
        else $error("process request dropped before done");
endmodule

bind cch_top cch_properties u_props (.ref_clk(ref_clk), .rst(rst), .core_in(core_in), .in_pins(in_pins),
    .trig_en(trig_en), .diag_en(diag_en), .diag_in(diag_in), .proc_done(proc_done), .diag_done(diag_done),
    .rd_en(rd_en), .rd_addr(rd_addr), .cmp_out(cmp_out), .process_irq_handler(process_irq_handler),
    .diag_irq_handler(diag_irq_handler), .diag_going(diag_going), .diag_chan(diag_chan), .diag_log(diag_log),
    .system_fault_indicator(system_fault_indicator), .rd_data(rd_data));

// [sim/counter_compare_hysteresis_irq_tb.sv]
// Self-checking bench for the compare and interrupt block
`timescale 1ns/1ps
module counter_compare_hysteresis_irq_tb;
    localparam int unsigned STEP = 8;
    logic                     ref_clk   = 1'b0;
    logic                     rst       = 1'b1;
    cch_pkg::cch_core_s [3:0] core_in;
    logic [15:0]              in_pins   = 16'h0000;
    logic [3:0]               trig_en   = 4'h1;
    logic                     diag_en   = 1'b1;
    cch_pkg::cch_diag_s       diag_in;
    logic                     proc_done = 1'b0;
    logic                     diag_done = 1'b0;
    logic                     rd_en     = 1'b0;
    logic [3:0]               rd_addr   = 4'h0;
    logic [3:0]               cmp_out;
    logic                     prc_irq;
    logic                     dg_irq;
    logic                     dg_going;
    logic [4:0]               dg_chan;
    logic                     dg_log;
    logic                     fault;
    logic [7:0]               rd_data;
    logic [7:0]               exp_q[$];
    logic                     rd_v      = 1'b0;
    logic [31:0]              cv;
    int                       n_fail    = 0;
    int                       cmp_count = 0;
    int                       len;
    int                       offs[8]   = '{0, -1, -2, -3, -1, 0, 3, -1};
    logic                     exps[8]   = '{1, 1, 1, 0, 0, 1, 1, 0};

    always #25 ref_clk = ~ref_clk;

    cch_top #(.PULSE_STEP_CYC(STEP)) dut (.ref_clk(ref_clk), .rst(rst), .core_in(core_in), .in_pins(in_pins),
        .trig_en(trig_en), .diag_en(diag_en), .diag_in(diag_in), .proc_done(proc_done), .diag_done(diag_done),
        .rd_en(rd_en), .rd_addr(rd_addr), .cmp_out(cmp_out), .process_irq_handler(prc_irq),
        .diag_irq_handler(dg_irq), .diag_going(dg_going), .diag_chan(dg_chan), .diag_log(dg_log),
        .system_fault_indicator(fault), .rd_data(rd_data));

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Read results checked in order of issue
    always @(posedge ref_clk) begin
        if (rd_v) begin
            if (exp_q.size() == 0)
                chk("read queue", 32'h1, 32'h0);
            else
                chk("rd_data", exp_q.pop_front(), rd_data);
        end
        rd_v <= rd_en;
    end

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        rd_en   <= 1'b1;
        rd_addr <= a;
        exp_q.push_back(e);
        @(posedge ref_clk);
        rd_en <= 1'b0;
        @(posedge ref_clk);
    endtask

    function automatic logic sig(input int w);
        case (w)
            0: return prc_irq;
            1: return dg_irq;
            default: return fault;
        endcase
    endfunction

    task automatic wait_sig(input int w, input logic lvl);
        int i;
        for (i = 0; i < 12 && sig(w) !== lvl; i++) begin
            @(posedge ref_clk);
            #1;
        end
        chk("wait level", lvl, sig(w));
        if (sig(w) !== lvl) final_report();
    endtask

    task automatic strobe(input logic dg);
        @(posedge ref_clk);
        if (dg) diag_done <= 1'b1;
        else proc_done <= 1'b1;
        @(posedge ref_clk);
        diag_done <= 1'b0;
        proc_done <= 1'b0;
    endtask

    task automatic put(input int off, input logic up);
        @(posedge ref_clk);
        core_in[0].value <= cv + off;
        core_in[0].up    <= up;
    endtask

    task automatic step(input int off, input logic up, input logic e);
        put(off, up);
        repeat (2) @(posedge ref_clk);
        #1;
        chk("cmp_out", e, cmp_out[0]);
    endtask

    task automatic pulse_len(input logic want);
        int i;
        len = 0;
        for (i = 0; i < 40; i++) begin
            @(posedge ref_clk);
            #1;
            if (cmp_out[0] === 1'b1) len++;
        end
        chk("pulse present", want, len > 0);
        if (want) chk("pulse length", 1, len >= STEP && len <= 2 * STEP + 1);
    endtask

    function automatic logic [7:0] b0(input logic ce);
        return {3'h0, diag_in.aux_miss, ce, diag_in.ext_err, 1'b0, diag_in.mod_fail};
    endfunction

    initial begin
        void'($urandom(67712));
        diag_in = cch_pkg::cch_diag_s'(5'($urandom));
        cv      = 32'($urandom_range(900, 100));
        for (int k = 0; k < 4; k++) begin
            core_in[k]       = '0;
            core_in[k].cmp   = cv;
            core_in[k].value = cv - 5;
            core_in[k].up    = 1'b1;
        end
        core_in[0].mode = cch_pkg::CCH_MODE_GE;
        core_in[0].hyst = 8'h03;
        core_in[1].mode = cch_pkg::CCH_MODE_LE;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        for (int a = 0; a < 16; a++) rd(4'(a), a == 0 ? b0(1'b0) : a == 1 ? {4'h0, diag_in.analog ? 4'h5 : 4'hf} :
            a == 2 ? {3'h0, diag_in.int_supply, 4'h0} : 8'h00);
        chk("cmp_out le", 1, cmp_out[1]);
        $display("test register reads done");
        step(-5, 1'b1, 1'b0);
        foreach (offs[i]) step(offs[i], 1'b1, exps[i]);
        step(0, 1'b1, 1'b1);
        core_in[0].hyst <= 8'h0a;
        step(-3, 1'b1, 1'b0);
        step(0, 1'b1, 1'b1);
        step(-5, 1'b1, 1'b1);
        step(-10, 1'b1, 1'b0);
        for (int h = 0; h < 2; h++) begin
            core_in[0].hyst <= 8'(h);
            step(0, 1'b1, 1'b1);
            step(-1, 1'b1, 1'b0);
        end
        $display("test hysteresis done");
        core_in[0].mode <= cch_pkg::CCH_MODE_PULSE;
        core_in[0].hyst <= 8'h03;
        step(-5, 1'b1, 1'b0);
        step(0, 1'b1, 1'b1);
        step(1, 1'b0, 1'b1);
        step(3, 1'b1, 1'b0);
        core_in[0].dur <= 8'h02;
        step(-5, 1'b1, 1'b0);
        put(0, 1'b1);
        pulse_len(1'b1);
        put(1, 1'b1);
        put(0, 1'b0);
        pulse_len(1'b0);
        put(-3, 1'b0);
        pulse_len(1'b1);
        put(0, 1'b1);
        pulse_len(1'b1);
        put(3, 1'b1);
        pulse_len(1'b0);
        $display("test pulse done");
        @(posedge ref_clk);
        in_pins[3] <= 1'b1;
        wait_sig(0, 1'b1);
        rd(4'h8, 8'h08);
        @(posedge ref_clk);
        in_pins[3] <= 1'b0;
        wait_sig(1, 1'b1);
        chk("process during diag", 0, prc_irq);
        chk("going flag", 0, dg_going);
        chk("diag channel", 3, dg_chan);
        chk("fault indicator", 1, fault);
        rd(4'h0, b0(1'b1));
        rd(4'h1, {3'h0, 1'b1, diag_in.analog ? 4'h5 : 4'hf});
        @(posedge ref_clk);
        in_pins[3] <= 1'b1;
        strobe(1'b1);
        wait_sig(0, 1'b1);
        rd(4'h8, 8'h08);
        strobe(1'b0);
        wait_sig(1, 1'b1);
        chk("going flag", 1, dg_going);
        chk("diag channel", 3, dg_chan);
        strobe(1'b1);
        wait_sig(2, 1'b0);
        repeat (5) @(posedge ref_clk);
        #1;
        chk("dropped event", 0, prc_irq);
        $display("test diagnostics done");
        trig_en <= 4'h6;
        @(posedge ref_clk);
        core_in[2].gate <= 1'b1;
        core_in[3].ovf  <= 1'b1;
        in_pins[0]      <= 1'b1;
        @(posedge ref_clk);
        core_in[3].ovf  <= 1'b0;
        wait_sig(0, 1'b1);
        rd(4'hb, 8'h41);
        rd(4'h8, 8'h00);
        strobe(1'b0);
        wait_sig(0, 1'b0);
        $display("test gate event done");
        final_report();
    end
endmodule
